// ### design/tsac_core.sv
/*
 * tsac_core: command interpreter for select, seek, authenticate and the
 * authentication gate of read block. Parses framed commands, drives the
 * rf front end request ports and emits framed responses.
 * Assumes rx bytes arrive one per valid cycle and the front end answers
 * each request with a one-cycle done pulse.
 */
`timescale 1ns/1ps
module tsac_core (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    output logic tx_valid_o,
    output logic [7:0] tx_data_o,
    input wire logic tx_ready_i,
    output logic [7:0] rsp_len_o,
    input wire logic rf_on_i,
    output logic tag_sel_req_o,
    input wire logic tag_done_i,
    input wire logic tag_present_i,
    input wire tsac_pkg::tsac_fam_t tag_family_i,
    input wire logic [55:0] tag_uid_i,
    output logic [3:0] key_slot_o,
    input wire logic [47:0] key_store_i,
    input wire logic key_store_ok_i,
    output logic auth_req_o,
    output logic [7:0] auth_block_o,
    output logic auth_key_b_o,
    output logic [47:0] auth_key_o,
    input wire logic auth_done_i,
    input wire logic auth_ok_i,
    output logic rd_req_o,
    output logic [7:0] rd_block_o,
    input wire logic rd_done_i,
    input wire logic rd_ok_i,
    input wire logic [127:0] rd_data_i
);
    import tsac_pkg::*;

    logic [7:0] cmd_buf [0:CMD_BUF_N-1];
    logic [7:0] rsp_buf [0:RSP_BUF_N-1];
    logic [1:0] rx_pos;
    logic [7:0] rx_len;
    logic [7:0] rx_cnt;
    logic [7:0] rx_sum;
    logic pend;
    logic take;
    logic seek_arm;
    logic authed;
    logic [7:0] authed_blk;
    logic [4:0] tx_pos;
    logic [7:0] tx_sum;
    logic [7:0] rsp_len;
    logic [7:0] next_byte;
    tsac_state_t st;

    assign take = pend && (st == S_IDLE || st == S_SEEK);
    assign key_slot_o = cmd_buf[2][3:0];

    // serial left-aligned so byte k is always the k-th byte sent
    function automatic logic [7:0] uid_byte(input tsac_fam_t fam, input logic [55:0] uid,
                                            input int k);
        logic [55:0] s;
        s = (fam == TSAC_FAM_SER7) ? uid : {uid[31:0], 24'h000000};
        return s[55-8*k -: 8];
    endfunction

    function automatic logic [7:0] type_byte(input tsac_fam_t fam);
        unique case (fam)
            TSAC_FAM_SER7: return TYPE_SER7;
            TSAC_FAM_1K: return TYPE_1K;
            TSAC_FAM_4K: return TYPE_4K;
            default: return TYPE_UNKNOWN;
        endcase
    endfunction

    // frame parser; frames arriving while a command is pending are dropped
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rx_pos <= 2'h0;
            rx_len <= 8'h00;
            rx_cnt <= 8'h00;
            rx_sum <= 8'h00;
            pend <= 1'b0;
            // cleared so key_slot_o is defined before the first frame
            for (int i = 0; i < CMD_BUF_N; i++) begin
                cmd_buf[i] <= 8'h00;
            end
        end else begin
            if (take) begin
                pend <= 1'b0;
            end
            if (rx_valid_i && !pend) begin
                unique case (rx_pos)
                    2'h0: rx_pos <= (rx_data_i == FRM_HEADER) ? 2'h1 : 2'h0;
                    2'h1: rx_pos <= (rx_data_i == FRM_RSVD) ? 2'h2 : 2'h0;
                    2'h2: begin
                        rx_len <= rx_data_i;
                        rx_sum <= rx_data_i;
                        rx_cnt <= 8'h00;
                        rx_pos <= (rx_data_i != 8'h00 && rx_data_i <= CMD_LEN_MAX) ? 2'h3 : 2'h0;
                    end
                    default: begin
                        if (rx_cnt == rx_len) begin
                            rx_pos <= 2'h0;
                            if (rx_data_i == rx_sum) begin
                                pend <= 1'b1;
                            end
                        end else begin
                            cmd_buf[rx_cnt[3:0]] <= rx_data_i;
                            rx_sum <= rx_sum + rx_data_i;
                            rx_cnt <= rx_cnt + 8'h01;
                        end
                    end
                endcase
            end
        end
    end

    always_comb begin
        if (tx_pos == 5'h00) begin
            next_byte = FRM_HEADER;
        end else if (tx_pos == 5'h01) begin
            next_byte = FRM_RSVD;
        end else if (tx_pos == 5'h02) begin
            next_byte = rsp_len;
        end else if (tx_pos == 5'(rsp_len + 8'h03)) begin
            next_byte = tx_sum;
        end else begin
            next_byte = rsp_buf[5'(tx_pos - 5'h03)];
        end
    end

    // command sequencing and response transmission
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            st <= S_IDLE;
            seek_arm <= 1'b0;
            authed <= 1'b0;
            authed_blk <= 8'h00;
            rsp_len <= 8'h00;
            rsp_len_o <= 8'h00;
            tx_pos <= 5'h00;
            tx_sum <= 8'h00;
            tx_valid_o <= 1'b0;
            tx_data_o <= 8'h00;
            tag_sel_req_o <= 1'b0;
            auth_req_o <= 1'b0;
            auth_block_o <= 8'h00;
            auth_key_b_o <= 1'b0;
            auth_key_o <= 48'h000000000000;
            rd_req_o <= 1'b0;
            rd_block_o <= 8'h00;
            for (int i = 0; i < RSP_BUF_N; i++) begin
                rsp_buf[i] <= 8'h00;
            end
        end else begin
            tag_sel_req_o <= 1'b0;
            auth_req_o <= 1'b0;
            rd_req_o <= 1'b0;
            unique case (st)
                S_IDLE, S_SEEK: begin
                    if (take) begin
                        // new command; a waiting seek is dropped here
                        seek_arm <= 1'b0;
                        rsp_len_o <= 8'h00;
                        rsp_len <= LEN_STATUS;
                        rsp_buf[0] <= cmd_buf[0];
                        tx_pos <= 5'h00;
                        tx_sum <= 8'h00;
                        st <= S_SEND;
                        if (cmd_buf[0] == CMD_SELECT) begin
                            authed <= 1'b0;
                            if (rf_on_i) begin
                                tag_sel_req_o <= 1'b1;
                                st <= S_SELW;
                            end else begin
                                rsp_buf[1] <= ST_RF_OFF;
                                rsp_len_o <= LEN_STATUS;
                            end
                        end else if (cmd_buf[0] == CMD_SEEK) begin
                            authed <= 1'b0;
                            seek_arm <= 1'b1;
                            rsp_buf[1] <= rf_on_i ? ST_OK_PROG : ST_RF_OFF;
                            rsp_len_o <= LEN_STATUS;
                        end else if (cmd_buf[0] == CMD_AUTH) begin
                            authed <= 1'b0;
                            auth_block_o <= cmd_buf[1];
                            auth_key_b_o <= cmd_buf[2] == KEY_DIRECT_B
                                || cmd_buf[2][7:4] == KEY_STORED_B;
                            auth_key_o <= {cmd_buf[3], cmd_buf[4], cmd_buf[5],
                                           cmd_buf[6], cmd_buf[7], cmd_buf[8]};
                            if (cmd_buf[2] == KEY_TRANSPORT) begin
                                auth_key_o <= KEY_ALL_ONES;
                            end else if (cmd_buf[2][7:4] == KEY_STORED_A
                                         || cmd_buf[2][7:4] == KEY_STORED_B) begin
                                auth_key_o <= key_store_i;
                            end
                            if ((cmd_buf[2][7:4] == KEY_STORED_A
                                 || cmd_buf[2][7:4] == KEY_STORED_B) && !key_store_ok_i) begin
                                rsp_buf[1] <= ST_KEY_FMT;
                                rsp_len_o <= LEN_STATUS;
                            end else begin
                                auth_req_o <= 1'b1;
                                st <= S_AUTHW;
                            end
                        end else if (cmd_buf[0] == CMD_READ) begin
                            if (authed && authed_blk == cmd_buf[1]) begin
                                rd_block_o <= cmd_buf[1];
                                rd_req_o <= 1'b1;
                                st <= S_READW;
                            end else begin
                                rsp_buf[1] <= ST_RD_FAIL;
                                rsp_len_o <= LEN_STATUS;
                            end
                        end else begin
                            // other commands belong to other blocks
                            st <= S_IDLE;
                        end
                    end else if (st == S_SEEK && rf_on_i && !tag_sel_req_o) begin
                        tag_sel_req_o <= 1'b1;
                        st <= S_SELW;
                    end
                end
                S_SELW: begin
                    if (tag_done_i) begin
                        tx_pos <= 5'h00;
                        tx_sum <= 8'h00;
                        if (tag_present_i) begin
                            rsp_len <= (tag_family_i == TSAC_FAM_SER7) ? LEN_SER7 : LEN_SER4;
                            rsp_len_o <= (tag_family_i == TSAC_FAM_SER7) ? LEN_SER7 : LEN_SER4;
                            rsp_buf[0] <= seek_arm ? CMD_SEEK : CMD_SELECT;
                            rsp_buf[1] <= type_byte(tag_family_i);
                            for (int k = 0; k < 7; k++) begin
                                rsp_buf[2+k] <= uid_byte(tag_family_i, tag_uid_i, k);
                            end
                            seek_arm <= 1'b0;
                            st <= S_SEND;
                        end else if (seek_arm) begin
                            st <= S_SEEK; // keep waiting
                        end else begin
                            rsp_buf[1] <= ST_NO_TAG;
                            rsp_len_o <= LEN_STATUS;
                            st <= S_SEND;
                        end
                    end
                end
                S_AUTHW: begin
                    if (auth_done_i) begin
                        authed <= auth_ok_i;
                        authed_blk <= auth_block_o;
                        rsp_buf[1] <= auth_ok_i ? ST_OK_PROG : (tag_present_i ? ST_RF_OFF : ST_NO_TAG);
                        rsp_len_o <= LEN_STATUS;
                        st <= S_SEND;
                    end
                end
                S_READW: begin
                    if (rd_done_i) begin
                        if (rd_ok_i) begin
                            rsp_len <= LEN_READ;
                            rsp_len_o <= LEN_READ;
                            rsp_buf[1] <= rd_block_o;
                            for (int k = 0; k < 16; k++) begin
                                rsp_buf[2+k] <= rd_data_i[127-8*k -: 8];
                            end
                        end else begin
                            rsp_buf[1] <= tag_present_i ? ST_RD_FAIL : ST_NO_TAG;
                            rsp_len_o <= LEN_STATUS;
                        end
                        st <= S_SEND;
                    end
                end
                S_SEND: begin
                    if (!tx_valid_o || tx_ready_i) begin
                        if (tx_pos == 5'(rsp_len + 8'h04)) begin
                            tx_valid_o <= 1'b0;
                            if (seek_arm) begin
                                rsp_len_o <= 8'h00;
                                st <= S_SEEK;
                            end else begin
                                st <= S_IDLE;
                            end
                        end else begin
                            tx_valid_o <= 1'b1;
                            tx_data_o <= next_byte;
                            if (tx_pos != 5'h00) begin
                                tx_sum <= tx_sum + next_byte;
                            end
                            tx_pos <= tx_pos + 5'h01;
                        end
                    end
                end
            endcase
        end
    end

    chk_sel_start: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        take && st == S_IDLE && cmd_buf[0] == CMD_SELECT && rf_on_i |=> tag_sel_req_o && st == S_SELW)
        else $error("select did not start");
    chk_sel_len: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        st == S_SELW && tag_done_i && tag_present_i
        |=> (rsp_len_o == LEN_SER4 || rsp_len_o == LEN_SER7) && st == S_SEND)
        else $error("select length wrong");
    chk_type_map: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        st == S_SELW && tag_done_i && tag_present_i && tag_family_i == TSAC_FAM_4K
        |=> rsp_buf[1] == TYPE_4K)
        else $error("tag type byte wrong");
    chk_ser7_len: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        st == S_SELW && tag_done_i && tag_present_i && tag_family_i == TSAC_FAM_SER7
        |=> rsp_len_o == LEN_SER7 && rsp_buf[8] == $past(tag_uid_i[7:0]))
        else $error("seven byte serial wrong");
    chk_rf_off: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        take && cmd_buf[0] == CMD_SELECT && !rf_on_i |=> rsp_buf[1] == ST_RF_OFF ##1 tx_valid_o)
        else $error("rf off select answer wrong");
    chk_seek_prog: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        take && cmd_buf[0] == CMD_SEEK && rf_on_i |=> rsp_buf[1] == ST_OK_PROG && seek_arm)
        else $error("seek progress answer wrong");
    chk_key_trans: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        take && cmd_buf[0] == CMD_AUTH && cmd_buf[2] == KEY_TRANSPORT
        |=> auth_req_o && auth_key_o == KEY_ALL_ONES && !auth_key_b_o)
        else $error("transport key wrong");
    chk_key_slot: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        take && cmd_buf[0] == CMD_AUTH && cmd_buf[2][7:4] == KEY_STORED_B && key_store_ok_i
        |=> auth_key_b_o && auth_key_o == $past(key_store_i))
        else $error("stored key b wrong");
    chk_read_gate: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        take && cmd_buf[0] == CMD_READ && !authed |=> !rd_req_o && rsp_buf[1] == ST_RD_FAIL)
        else $error("unauthenticated read passed");
    chk_busy_len: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        st == S_SEEK || st == S_AUTHW |-> rsp_len_o == 8'h00)
        else $error("length visible while busy");
    chk_hdr_first: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        st == S_SEND && tx_pos == 5'h01 && tx_valid_o |-> tx_data_o == FRM_HEADER)
        else $error("header byte wrong");

    cov_seek_found: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        st == S_SELW && seek_arm && tag_done_i && tag_present_i);
    cov_auth_ok: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        st == S_AUTHW && auth_done_i && auth_ok_i);
    cov_seek_abandon: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        st == S_SEEK && take);
endmodule

// ### design/tsac_pkg.sv
/*
 * tsac_pkg: command codes, status codes, tag family codes and frame
 * constants for the tag select / seek / authenticate command interpreter.
 * Assumes byte-wide framed traffic from a host controller.
 */
package tsac_pkg;
    // frame bytes
    localparam logic [7:0] FRM_HEADER = 8'hFF;
    localparam logic [7:0] FRM_RSVD = 8'h00;
    localparam logic [7:0] CMD_LEN_MAX = 8'h09;
    localparam int CMD_BUF_N = 9;
    localparam int RSP_BUF_N = 18;
    // command codes
    localparam logic [7:0] CMD_SEEK = 8'h82;
    localparam logic [7:0] CMD_SELECT = 8'h83;
    localparam logic [7:0] CMD_AUTH = 8'h85;
    localparam logic [7:0] CMD_READ = 8'h86;
    // status and error codes
    localparam logic [7:0] ST_OK_PROG = 8'h4C;
    localparam logic [7:0] ST_NO_TAG = 8'h4E;
    localparam logic [7:0] ST_RF_OFF = 8'h55;
    localparam logic [7:0] ST_KEY_FMT = 8'h45;
    localparam logic [7:0] ST_RD_FAIL = 8'h46;
    // response lengths
    localparam logic [7:0] LEN_STATUS = 8'h02;
    localparam logic [7:0] LEN_SER4 = 8'h06;
    localparam logic [7:0] LEN_SER7 = 8'h09;
    localparam logic [7:0] LEN_READ = 8'h12;
    // tag type byte values
    localparam logic [7:0] TYPE_SER7 = 8'h01;
    localparam logic [7:0] TYPE_1K = 8'h02;
    localparam logic [7:0] TYPE_4K = 8'h03;
    localparam logic [7:0] TYPE_UNKNOWN = 8'hFF;
    // key type values
    localparam logic [7:0] KEY_DIRECT_A = 8'hAA;
    localparam logic [7:0] KEY_DIRECT_B = 8'hBB;
    localparam logic [7:0] KEY_TRANSPORT = 8'hFF;
    localparam logic [3:0] KEY_STORED_A = 4'h1;
    localparam logic [3:0] KEY_STORED_B = 4'h2;
    localparam logic [47:0] KEY_ALL_ONES = 48'hFFFFFFFFFFFF;
    // tag family reported by the rf front end
    typedef enum logic [1:0] {
        TSAC_FAM_UNKNOWN = 2'h0,
        TSAC_FAM_SER7 = 2'h1,
        TSAC_FAM_1K = 2'h2,
        TSAC_FAM_4K = 2'h3
    } tsac_fam_t;
    typedef enum logic [5:0] {
        S_IDLE = 6'b000001,
        S_SELW = 6'b000010,
        S_SEEK = 6'b000100,
        S_AUTHW = 6'b001000,
        S_READW = 6'b010000,
        S_SEND = 6'b100000
    } tsac_state_t;
endpackage

// ### sim/test_tag_select_auth_commands.sv
/*
 * test_tag_select_auth_commands: self-checking bench for tsac_core with rf model.
 * Assumes the response sink is always ready; frames go out one byte a cycle.
 */
`timescale 1ns/1ps
module test_tag_select_auth_commands;
    import tsac_pkg::*;
    logic clk_sys_i = 1'b0, rst_n_i = 1'b0, rx_valid = 1'b0, rf_on = 1'b0, present = 1'b0;
    logic slow = 1'b1, tx_ready = 1'b1, tx_valid, tag_sel_req, tag_done, key_ok, auth_req;
    logic auth_done, auth_ok, auth_key_b, rd_req, rd_done, rd_ok = 1'b1;
    logic [7:0] rx_data = 8'h00, tx_data, rsp_len, auth_block, rd_block;
    logic [3:0] key_slot;
    logic [47:0] key_store, auth_key, cfg_key = KEY_ALL_ONES;
    logic [55:0] uid = 56'h11223344556677;
    logic [127:0] rd_data = 128'h000102030405060708090A0B0C0D0E0F;
    tsac_fam_t fam = TSAC_FAM_1K;
    int bad_count = 0, total_checks = 0;
    initial forever #12.5 clk_sys_i = ~clk_sys_i;
    tsac_core i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .rx_valid_i(rx_valid),
        .rx_data_i(rx_data), .tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_ready_i(tx_ready),
        .rsp_len_o(rsp_len), .rf_on_i(rf_on), .tag_sel_req_o(tag_sel_req),
        .tag_done_i(tag_done), .tag_present_i(present), .tag_family_i(fam), .tag_uid_i(uid),
        .key_slot_o(key_slot), .key_store_i(key_store), .key_store_ok_i(key_ok),
        .auth_req_o(auth_req), .auth_block_o(auth_block), .auth_key_b_o(auth_key_b),
        .auth_key_o(auth_key), .auth_done_i(auth_done), .auth_ok_i(auth_ok), .rd_req_o(rd_req),
        .rd_block_o(rd_block), .rd_done_i(rd_done), .rd_ok_i(rd_ok), .rd_data_i(rd_data));
    tsac_rf_model i_rf (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .slow_i(slow),
        .tag_sel_req_i(tag_sel_req), .auth_req_i(auth_req), .rd_req_i(rd_req),
        .key_slot_i(key_slot), .auth_key_i(auth_key), .cfg_key_i(cfg_key),
        .tag_done_o(tag_done), .auth_done_o(auth_done), .auth_ok_o(auth_ok), .rd_done_o(rd_done),
        .key_store_o(key_store), .key_store_ok_o(key_ok));
    task report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // checksum covers length and everything after it, header excluded
    task send(input logic [7:0] b[$]);
        logic [7:0] f[$];
        logic [7:0] s;
        f = {FRM_HEADER, FRM_RSVD, 8'(b.size()), b};
        s = 8'(b.size());
        foreach (b[i]) s += b[i];
        f.push_back(s);
        foreach (f[i]) begin
            @(posedge clk_sys_i);
            rx_valid <= 1'b1;
            rx_data <= f[i];
        end
        @(posedge clk_sys_i);
        rx_valid <= 1'b0;
    endtask
    task get_byte(output logic [7:0] v);
        int k;
        k = 0;
        do begin
            @(posedge clk_sys_i);
            k++;
        end while (tx_valid !== 1'b1 && k < 400);
        if (k >= 400) chk("tx_valid", 8'h01, 8'h00);
        v = tx_data;
    endtask
    task expect_rsp(input logic [7:0] e[$]);
        logic [7:0] v;
        logic [7:0] s;
        get_byte(v);
        chk("header", FRM_HEADER, v);
        get_byte(v);
        chk("reserved", FRM_RSVD, v);
        get_byte(v);
        chk("length", 8'(e.size()), v);
        s = v;
        foreach (e[i]) begin
            get_byte(v);
            chk("payload", e[i], v);
            s += e[i];
        end
        get_byte(v);
        chk("checksum", s, v);
    endtask
    task expect_tag(input logic [7:0] cmd, input logic [7:0] ty);
        logic [7:0] e[$];
        e = {cmd, ty};
        if (fam == TSAC_FAM_SER7)
            for (int k = 0; k < 7; k++) e.push_back(uid[55 - 8 * k -: 8]);
        else
            for (int k = 0; k < 4; k++) e.push_back(uid[31 - 8 * k -: 8]);
        expect_rsp(e);
    endtask
    task t_select_errors;
        send('{CMD_SELECT});
        expect_rsp('{CMD_SELECT, ST_RF_OFF});
        @(posedge clk_sys_i);
        rf_on <= 1'b1;
        send('{CMD_SELECT});
        repeat (2) @(posedge clk_sys_i);
        chk("rsp_len busy", 8'h00, rsp_len);
        expect_rsp('{CMD_SELECT, ST_NO_TAG});
    endtask
    task t_select_families;
        logic [7:0] ty[4];
        ty = '{TYPE_UNKNOWN, TYPE_SER7, TYPE_1K, TYPE_4K};
        @(posedge clk_sys_i);
        present <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            fam <= tsac_fam_t'(i);
            send('{CMD_SELECT});
            expect_tag(CMD_SELECT, ty[i]);
        end
        chk("rsp_len ready", LEN_SER4, rsp_len);
    endtask
    task t_auth_read;
        logic [7:0] e[$];
        send('{CMD_AUTH, 8'h01, KEY_TRANSPORT});
        expect_rsp('{CMD_AUTH, ST_OK_PROG});
        chk("auth_block", 8'h01, auth_block);
        chk("auth_key_b", 8'h00, {7'h00, auth_key_b});
        e = '{CMD_READ, 8'h01};
        for (int k = 0; k < 16; k++) e.push_back(rd_data[127 - 8 * k -: 8]);
        send('{CMD_READ, 8'h01});
        expect_rsp(e);
        chk("rd_block", 8'h01, rd_block);
        send('{CMD_READ, 8'h02});
        expect_rsp('{CMD_READ, ST_RD_FAIL});
        send('{CMD_AUTH, 8'h05, KEY_DIRECT_A, 8'h11, 8'h23, 8'h43, 8'hFC, 8'h97, 8'hCD});
        expect_rsp('{CMD_AUTH, ST_RF_OFF});
        send('{CMD_SELECT});
        expect_tag(CMD_SELECT, TYPE_4K);
        send('{CMD_AUTH, 8'h02, 8'h1F});
        expect_rsp('{CMD_AUTH, ST_KEY_FMT});
        cfg_key <= {12{4'h3}};
        send('{CMD_AUTH, 8'h02, 8'h23});
        expect_rsp('{CMD_AUTH, ST_OK_PROG});
        chk("auth_key_b", 8'h01, {7'h00, auth_key_b});
        cfg_key <= 48'h112343FC97CD;
        send('{CMD_AUTH, 8'h04, KEY_DIRECT_B, 8'h11, 8'h23, 8'h43, 8'hFC, 8'h97, 8'hCD});
        expect_rsp('{CMD_AUTH, ST_OK_PROG});
        chk("auth_key_b", 8'h01, {7'h00, auth_key_b});
        // authenticated block, but the front end reports a failed read
        rd_ok <= 1'b0;
        send('{CMD_READ, 8'h04});
        expect_rsp('{CMD_READ, ST_RD_FAIL});
        rd_ok <= 1'b1;
    endtask
    task t_seek;
        @(posedge clk_sys_i);
        present <= 1'b0;
        send('{CMD_SEEK});
        expect_rsp('{CMD_SEEK, ST_OK_PROG});
        repeat (20) @(posedge clk_sys_i);
        chk("rsp_len seek", 8'h00, rsp_len);
        present <= 1'b1;
        expect_tag(CMD_SEEK, TYPE_4K);
        @(posedge clk_sys_i);
        present <= 1'b0;
        rf_on <= 1'b0;
        send('{CMD_SEEK});
        expect_rsp('{CMD_SEEK, ST_RF_OFF});
        @(posedge clk_sys_i);
        rf_on <= 1'b1;
        slow <= 1'b0;
        send('{CMD_SELECT});
        expect_rsp('{CMD_SELECT, ST_NO_TAG});
    endtask
    initial begin
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        t_select_errors();
        t_select_families();
        t_auth_read();
        t_seek();
        report_and_stop();
    end
    initial begin
        #400000;
        bad_count++;
        report_and_stop();
    end
endmodule

// ### sim/tsac_rf_model.sv
/*
 * tsac_rf_model: behavioural rf front end and key store facing tsac_core.
 * Assumes the bench drives field, tag and expected-key settings directly.
 */
`timescale 1ns/1ps
module tsac_rf_model (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic slow_i,
    input wire logic tag_sel_req_i,
    input wire logic auth_req_i,
    input wire logic rd_req_i,
    input wire logic [3:0] key_slot_i,
    input wire logic [47:0] auth_key_i,
    input wire logic [47:0] cfg_key_i,
    output logic tag_done_o,
    output logic auth_done_o,
    output logic auth_ok_o,
    output logic rd_done_o,
    output logic [47:0] key_store_o,
    output logic key_store_ok_o
);
    logic [3:0] sel_sr;
    logic [3:0] auth_sr;
    logic [3:0] rd_sr;
    // slow mode taps later stages so the core must really wait
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            sel_sr <= 4'h0;
            auth_sr <= 4'h0;
            rd_sr <= 4'h0;
        end else begin
            sel_sr <= {sel_sr[2:0], tag_sel_req_i};
            auth_sr <= {auth_sr[2:0], auth_req_i};
            rd_sr <= {rd_sr[2:0], rd_req_i};
        end
    end
    assign tag_done_o = slow_i ? sel_sr[3] : sel_sr[0];
    assign auth_done_o = slow_i ? auth_sr[3] : auth_sr[0];
    assign rd_done_o = slow_i ? rd_sr[3] : rd_sr[0];
    // login passes only when the key used matches the one the tag holds
    assign auth_ok_o = (auth_key_i == cfg_key_i);
    // slot 15 holds a badly formatted key
    assign key_store_o = {12{key_slot_i}};
    assign key_store_ok_o = (key_slot_i != 4'hF);
endmodule
